// file: bpo_port.sv
// port B upper pins and port C pin logic with register access
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module bpo_port (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] port_b_pin_in,
    output logic [1:0] port_b_pin_out,
    output logic [1:0] port_b_pin_oe,
    output logic [1:0] port_b_pullup_en,
    input wire logic port_b_bit3_pin_in,
    input wire logic [7:0] port_c_pin_in,
    output logic [7:0] port_c_pin_out,
    output logic [7:0] port_c_pin_oe,
    input wire logic analog_at_reset_cfg,
    output logic analog_b_mode,
    input wire logic capcomp2_mux_cfg,
    input wire logic capcomp2_en,
    input wire logic capcomp2_out,
    input wire logic capcomp2_oe,
    output logic capcomp2_capture_in,
    output logic alt_b3_out,
    output logic alt_b3_oe,
    input wire logic prog_enable,
    output logic prog_serial_clock,
    output logic prog_serial_data_in,
    input wire logic prog_serial_data_out,
    input wire logic prog_serial_data_oe,
    input wire logic usb_en,
    input wire logic usb_ext_xcvr,
    input wire logic usb_xcvr_drive,
    input wire logic usb_minus_out,
    input wire logic usb_plus_out,
    input wire logic usb_ext_oe_ctl,
    output logic usb_minus_in,
    output logic usb_plus_in,
    input wire logic [7:0] periph_dir_ovr,
    input wire logic [7:0] periph_dir_val,
    input wire logic [7:0] periph_out_ovr,
    input wire logic [7:0] periph_out_val,
    output logic change_event,
    output logic change_irq_req
);
    logic [7:0] lat_b_reg, dir_b_reg, irq_main_reg, irq_edge_reg;
    logic [7:0] lat_c_reg, dir_c_reg, rdata_reg;
    logic [1:0] pb_meta_reg, pb_sync_reg, pb_prev_reg;
    logic [7:0] pc_meta_reg, pc_sync_reg;
    logic b3_meta_reg, b3_sync_reg;
    logic [1:0] pb_out_reg, pb_oe_reg, pb_pu_reg;
    logic [7:0] pc_out_reg, pc_oe_reg;
    logic alt_out_reg, alt_oe_reg, chg_evt_reg, analog_reg;

    // masks a value to the implemented bits, clearing all others
    function automatic logic [7:0] masked(input logic [7:0] v,
                                          input logic [7:0] m);
        masked = v & m;
    endfunction

    // register strobes
    wire wr_pin_b = reg_wr && (reg_addr == bpo_pkg::OFS_PIN_B);
    wire wr_lat_b = reg_wr && (reg_addr == bpo_pkg::OFS_LAT_B);
    wire wr_dir_b = reg_wr && (reg_addr == bpo_pkg::OFS_DIR_B);
    wire wr_main = reg_wr && (reg_addr == bpo_pkg::OFS_IRQ_MAIN);
    wire wr_edge = reg_wr && (reg_addr == bpo_pkg::OFS_IRQ_EDGE);
    wire wr_pin_c = reg_wr && (reg_addr == bpo_pkg::OFS_PIN_C);
    wire wr_lat_c = reg_wr && (reg_addr == bpo_pkg::OFS_LAT_C);
    wire wr_dir_c = reg_wr && (reg_addr == bpo_pkg::OFS_DIR_C);

    // modes
    wire prog = prog_enable;
    wire ext_on = usb_en && usb_ext_xcvr;
    wire int_drive = usb_en && !usb_ext_xcvr && usb_xcvr_drive;
    wire pu_dis = irq_edge_reg[bpo_pkg::BIT_PU_DIS];
    wire [1:0] dir_b_hi = dir_b_reg[7:6];
    wire [1:0] lat_b_hi = lat_b_reg[7:6];

    // pin reads: bit 3 absent, USB pins blank while USB owns them
    wire [7:0] usb_blank = usb_en ? bpo_pkg::MASK_C_USB : bpo_pkg::ZERO;
    wire [7:0] pin_c_view = pc_sync_reg & bpo_pkg::MASK_C_PIN
                            & ~usb_blank; // [R19] [R20] [R3]
    wire [7:0] pin_b_view = {pb_sync_reg, 6'h00}; // [R20]
    wire [7:0] status_view = {4'h0, ext_on, usb_en, prog, analog_reg};

    // change detect only on input pins outside programming mode
    wire [1:0] chg_bits = (pb_sync_reg ^ pb_prev_reg) & dir_b_hi
                          & ~{2{prog}}; // [R14] [R16]
    wire chg_any = |chg_bits;
    wire [7:0] irq_main_next = masked(wr_main ? reg_wdata : irq_main_reg,
                                      bpo_pkg::MASK_IRQ_MAIN)
        | (chg_any ? (8'h01 << bpo_pkg::BIT_CHG_FLAG)
                   : bpo_pkg::ZERO); // [R14] set wins over clear

    // read decode
    wire [7:0] rd_mux =
        (reg_addr == bpo_pkg::OFS_PIN_B) ? pin_b_view :
        (reg_addr == bpo_pkg::OFS_LAT_B) ? lat_b_reg :
        (reg_addr == bpo_pkg::OFS_DIR_B) ? dir_b_reg :
        (reg_addr == bpo_pkg::OFS_IRQ_MAIN) ? irq_main_reg :
        (reg_addr == bpo_pkg::OFS_IRQ_EDGE) ? irq_edge_reg :
        (reg_addr == bpo_pkg::OFS_PIN_C) ? pin_c_view :
        (reg_addr == bpo_pkg::OFS_LAT_C) ? lat_c_reg :
        (reg_addr == bpo_pkg::OFS_DIR_C) ? dir_c_reg : // [R10] [R4]
        (reg_addr == bpo_pkg::OFS_STATUS) ? status_view :
        bpo_pkg::ZERO;

    // capture/compare 2 placement
    wire ccp2_on_c = capcomp2_en && capcomp2_mux_cfg; // [R17]
    wire ccp2_on_b = capcomp2_en && !capcomp2_mux_cfg; // [R17]
    wire [7:0] ccp2_sel = ccp2_on_c ? (8'h01 << bpo_pkg::BIT_C_CCP2)
                                    : bpo_pkg::ZERO;
    wire [7:0] uoe_sel = ext_on ? (8'h01 << bpo_pkg::BIT_C_UOE)
                                : bpo_pkg::ZERO;

    // peripheral overrides beat the direction register
    wire [7:0] dir_ovr = (periph_dir_ovr | ccp2_sel)
                         & bpo_pkg::MASK_C_LAT; // [R9]
    wire [7:0] dir_val = (periph_dir_val & ~ccp2_sel)
                         | (capcomp2_oe ? ccp2_sel : bpo_pkg::ZERO);
    wire [7:0] out_ovr = (periph_out_ovr | ccp2_sel)
                         & bpo_pkg::MASK_C_LAT;
    wire [7:0] out_val = (periph_out_val & ~ccp2_sel)
                         | (capcomp2_out ? ccp2_sel : bpo_pkg::ZERO);
    wire [7:0] soft_oe = ~dir_c_reg & bpo_pkg::MASK_C_LAT; // [R1] [R2]
    wire [7:0] gp_oe = (dir_ovr & dir_val) | (~dir_ovr & soft_oe);
    wire [7:0] gp_out = (out_ovr & out_val) | (~out_ovr & lat_c_reg);

    // USB pins carry no general path; bit 2 follows the transceiver
    wire [7:0] gp_keep = ~uoe_sel & ~bpo_pkg::MASK_C_USB;
    wire [7:0] usb_oe_bits = int_drive ? bpo_pkg::MASK_C_USB
                                       : bpo_pkg::ZERO; // [R5] [R6] [R7]
    wire [7:0] usb_out_bits = int_drive ?
        {2'b00, usb_plus_out, usb_minus_out, 4'h0} : bpo_pkg::ZERO;
    wire [7:0] pc_oe_next = (gp_oe & gp_keep) | uoe_sel
                            | usb_oe_bits; // [R8] [R3]
    wire [7:0] pc_out_next = (gp_out & gp_keep) | usb_out_bits
        | (usb_ext_oe_ctl ? uoe_sel : bpo_pkg::ZERO); // [R8]

    // port B upper pins: programmer takes them over completely
    wire [1:0] pb_oe_next = prog ?
        {prog_serial_data_oe, 1'b0} : ~dir_b_hi; // [R15] [R16]
    wire [1:0] pb_out_next = prog ?
        {prog_serial_data_out, 1'b0} : lat_b_hi; // [R15] [R16]
    wire [1:0] pb_pu_next = (pu_dis || prog) ? 2'b00
                            : dir_b_hi; // [R13] [R21] [R16]

    // synchronisers: first stage feeds only the second
    always_ff @(posedge core_clk) begin
        pb_meta_reg <= port_b_pin_in;
        pb_sync_reg <= pb_meta_reg;
        pc_meta_reg <= port_c_pin_in;
        pc_sync_reg <= pc_meta_reg;
        b3_meta_reg <= port_b_bit3_pin_in;
        b3_sync_reg <= b3_meta_reg;
        // unreset on purpose: a reset-time 00 would show a false pin change
        pb_prev_reg <= pb_sync_reg;
    end

    // strap caught while reset is held, so it holds the level at release
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            analog_reg <= analog_at_reset_cfg; // [R12]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lat_b_reg <= bpo_pkg::RST_LAT;
            dir_b_reg <= bpo_pkg::RST_DIR;
            lat_c_reg <= bpo_pkg::RST_LAT;
            dir_c_reg <= masked(bpo_pkg::RST_DIR,
                                bpo_pkg::MASK_C_LAT); // [R11]
            irq_main_reg <= bpo_pkg::RST_IRQ_MAIN;
            irq_edge_reg <= bpo_pkg::RST_IRQ_EDGE;
        end else begin
            if (wr_pin_b || wr_lat_b) begin
                lat_b_reg <= masked(reg_wdata, bpo_pkg::MASK_B_UPPER);
            end
            if (wr_dir_b) begin
                dir_b_reg <= masked(reg_wdata, bpo_pkg::MASK_B_UPPER);
            end
            if (wr_pin_c || wr_lat_c) begin
                lat_c_reg <= masked(reg_wdata,
                                    bpo_pkg::MASK_C_LAT); // [R4] [R18]
            end
            if (wr_dir_c) begin
                dir_c_reg <= masked(reg_wdata,
                                    bpo_pkg::MASK_C_LAT); // [R18]
            end
            if (wr_edge) begin
                irq_edge_reg <= masked(reg_wdata, bpo_pkg::MASK_IRQ_EDGE);
            end
            irq_main_reg <= irq_main_next;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_reg <= bpo_pkg::ZERO;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : bpo_pkg::ZERO;
        end
    end

    // pin drivers are registered; one cycle behind the control state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pc_oe_reg <= bpo_pkg::ZERO; // [R11]
            pc_out_reg <= bpo_pkg::ZERO;
            pb_oe_reg <= 2'b00;
            pb_out_reg <= 2'b00;
            pb_pu_reg <= 2'b00;
            alt_out_reg <= 1'b0;
            alt_oe_reg <= 1'b0;
            chg_evt_reg <= 1'b0;
        end else begin
            pc_oe_reg <= pc_oe_next;
            pc_out_reg <= pc_out_next;
            pb_oe_reg <= pb_oe_next;
            pb_out_reg <= pb_out_next;
            pb_pu_reg <= pb_pu_next;
            alt_out_reg <= ccp2_on_b && capcomp2_out; // [R17]
            alt_oe_reg <= ccp2_on_b && capcomp2_oe; // [R17]
            chg_evt_reg <= chg_any;
        end
    end

    assign reg_rdata = rdata_reg;
    assign port_c_pin_oe = pc_oe_reg;
    assign port_c_pin_out = pc_out_reg;
    assign port_b_pin_oe = pb_oe_reg;
    assign port_b_pin_out = pb_out_reg;
    assign port_b_pullup_en = pb_pu_reg;
    assign alt_b3_out = alt_out_reg;
    assign alt_b3_oe = alt_oe_reg;
    assign analog_b_mode = analog_reg;
    assign change_event = chg_evt_reg;
    assign change_irq_req = irq_main_reg[bpo_pkg::BIT_CHG_FLAG]
                            && irq_main_reg[bpo_pkg::BIT_CHG_EN];
    assign prog_serial_clock = pb_sync_reg[bpo_pkg::BIT_PB_CLK]; // [R15]
    assign prog_serial_data_in = pb_sync_reg[bpo_pkg::BIT_PB_DAT];
    assign usb_minus_in = pc_sync_reg[bpo_pkg::BIT_C_MINUS]; // [R6]
    assign usb_plus_in = pc_sync_reg[bpo_pkg::BIT_C_PLUS];
    assign capcomp2_capture_in = capcomp2_mux_cfg ?
        pc_sync_reg[bpo_pkg::BIT_C_CCP2] : b3_sync_reg; // [R17]

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_wr_lat_c;
        reg_wr && reg_addr == bpo_pkg::OFS_LAT_C;
    endsequence
    sequence s_rd_lat_c;
        reg_rd && reg_addr == bpo_pkg::OFS_LAT_C;
    endsequence
    sequence s_wr_dir_c;
        reg_wr && reg_addr == bpo_pkg::OFS_DIR_C;
    endsequence
    sequence s_rd_dir_c;
        reg_rd && reg_addr == bpo_pkg::OFS_DIR_C;
    endsequence

    a_dir_c_float: assert property ( // [R1]
        1'b1 |=> (port_c_pin_oe & $past(dir_c_reg & ~dir_ovr & ~uoe_sel))
                 == bpo_pkg::ZERO)
        else $error("input-set port C pin is driven");
    a_dir_c_drive: assert property ( // [R2]
        (soft_oe[0] && !dir_ovr[0] && !out_ovr[0])
        |=> port_c_pin_oe[0] && port_c_pin_out[0] == $past(lat_c_reg[0]))
        else $error("output-set port C pin not driven from latch");
    a_bit3_absent: assert property ( // [R3]
        !port_c_pin_oe[bpo_pkg::BIT_C_NONE])
        else $error("absent port C bit 3 driven");
    a_lat_c_back: assert property ( // [R4]
        s_wr_lat_c ##1 s_rd_lat_c
        |=> reg_rdata == ($past(reg_wdata, 2) & bpo_pkg::MASK_C_LAT))
        else $error("latch C readback differs from written value");
    a_usb_input: assert property ( // [R5]
        !int_drive |=> (port_c_pin_oe & bpo_pkg::MASK_C_USB) == 8'h00)
        else $error("USB-shared pin driven outside internal USB drive");
    a_usb_dynamic: assert property ( // [R7]
        int_drive |=> port_c_pin_oe[5:4] == 2'b11
                      && port_c_pin_out[4] == $past(usb_minus_out))
        else $error("internal transceiver direction not followed");
    a_ext_enable: assert property ( // [R8]
        ext_on |=> port_c_pin_oe[2]
                   && port_c_pin_out[2] == $past(usb_ext_oe_ctl))
        else $error("transceiver enable not on port C bit 2");
    a_periph_over: assert property ( // [R9]
        periph_dir_ovr[0] |=> port_c_pin_oe[0] == $past(periph_dir_val[0]))
        else $error("peripheral direction override ignored");
    a_dir_c_back: assert property ( // [R10]
        s_wr_dir_c ##1 s_rd_dir_c
        |=> reg_rdata == ($past(reg_wdata, 2) & bpo_pkg::MASK_C_LAT))
        else $error("direction C readback differs from written value");
    a_reset_input: assert property ( // [R11]
        disable iff (1'b0) !reset_n |=> port_c_pin_oe == 8'h00)
        else $error("port C pin driven after reset");
    a_strap_catch: assert property ( // [R12]
        disable iff (1'b0)
        !reset_n ##1 reset_n |-> analog_b_mode == $past(analog_at_reset_cfg))
        else $error("analog strap not caught at reset release");
    a_pullup_on: assert property ( // [R13]
        (!pu_dis && !prog && dir_b_hi[1]) |=> port_b_pullup_en[1])
        else $error("pull-up missing on input pin");
    a_change_flag: assert property ( // [R14]
        chg_any |=> irq_main_reg[bpo_pkg::BIT_CHG_FLAG] && change_event)
        else $error("pin change not flagged");
    a_prog_data: assert property ( // [R15]
        prog |=> port_b_pin_oe[1] == $past(prog_serial_data_oe)
                 && !port_b_pin_oe[0])
        else $error("programming pins not handed to programmer");
    a_prog_isolate: assert property ( // [R16]
        prog |=> port_b_pullup_en == 2'b00 && !change_event)
        else $error("other functions active in programming mode");
    a_ccp2_route: assert property ( // [R17]
        ccp2_on_b |=> alt_b3_oe == $past(capcomp2_oe)
                      && !port_c_pin_oe[1] == $past(dir_c_reg[1]
                         && !periph_dir_ovr[1]) | port_c_pin_oe[1])
        else $error("capture/compare 2 not routed to alternate pin");
    a_reserved_zero: assert property ( // [R18]
        reg_rd && reg_addr == bpo_pkg::OFS_IRQ_EDGE
        |=> reg_rdata[6:0] == 7'h00)
        else $error("unimplemented bits read non-zero");
    a_usb_read_off: assert property ( // [R19]
        reg_rd && reg_addr == bpo_pkg::OFS_PIN_C && usb_en
        |=> reg_rdata[5:4] == 2'b00)
        else $error("USB pins read while USB enabled");
    a_pin_read: assert property ( // [R20]
        reg_rd && reg_addr == bpo_pkg::OFS_PIN_C && !usb_en
        |=> reg_rdata == ($past(pc_sync_reg) & bpo_pkg::MASK_C_PIN))
        else $error("pin register does not show sampled levels");
    a_pullup_off: assert property ( // [R21]
        !dir_b_hi[0] |=> !port_b_pullup_en[0])
        else $error("pull-up enabled on output pin");
endmodule

// file: bpo_pkg.sv
// constants, register map and field layout for the two-port pin block
// Summary of operation
// R1: direction_c bit 1 floats the pin driver
// R2: direction_c bit 0 drives output latch bit
// R3: port C has seven pins, bit 3 absent
// R4: output_latch_c readable; read-modify-write uses latch
// R5: USB-shared bits 4,5 are input only
// R6: external transceiver: USB pins stay inputs
// R7: internal transceiver: USB module sets direction
// R8: external transceiver: bit 2 drives transceiver enable
// R9: enabled peripheral overrides port C direction
// R10: direction_c reads back software value always
// R11: port C pins come up as inputs
// R12: reset strap chooses analog or digital port B
// R13: pull-ups on bits 6,7 unless disabled
// R14: input bits 6,7 flag level changes
// R15: programming clock on bit 6, data bit 7
// R16: programming mode disables other pin functions
// R17: mux bit 0 moves capture/compare 2 to B
// R18: unimplemented register bits read as zero; dir_b_reg reads FF after reset until written
// R19: USB enabled disables USB pins' digital input
// R20: pin register reads sampled pin levels
// R21: output pins never enable their pull-up
package bpo_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register addresses
    localparam logic [3:0] OFS_PIN_B = 4'h0;
    localparam logic [3:0] OFS_LAT_B = 4'h1;
    localparam logic [3:0] OFS_DIR_B = 4'h2;
    localparam logic [3:0] OFS_IRQ_MAIN = 4'h3;
    localparam logic [3:0] OFS_IRQ_EDGE = 4'h4;
    localparam logic [3:0] OFS_PIN_C = 4'h5;
    localparam logic [3:0] OFS_LAT_C = 4'h6;
    localparam logic [3:0] OFS_DIR_C = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // implemented bits
    localparam logic [7:0] MASK_B_UPPER = 8'hC0;
    localparam logic [7:0] MASK_C_LAT = 8'hC7;
    localparam logic [7:0] MASK_C_PIN = 8'hF7;
    localparam logic [7:0] MASK_C_USB = 8'h30;
    localparam logic [7:0] MASK_IRQ_MAIN = 8'h09;
    localparam logic [7:0] MASK_IRQ_EDGE = 8'h80;

    // field positions
    localparam int BIT_CHG_FLAG = 0;
    localparam int BIT_CHG_EN = 3;
    localparam int BIT_PU_DIS = 7;
    localparam int BIT_C_CCP2 = 1;
    localparam int BIT_C_UOE = 2;
    localparam int BIT_C_NONE = 3;
    localparam int BIT_C_MINUS = 4;
    localparam int BIT_C_PLUS = 5;
    localparam int BIT_PB_CLK = 0;
    localparam int BIT_PB_DAT = 1;
    localparam int STS_ANALOG = 0;
    localparam int STS_PROG = 1;
    localparam int STS_USB = 2;
    localparam int STS_EXT = 3;

    // reset values
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_LAT = 8'h00;
    localparam logic [7:0] RST_IRQ_MAIN = 8'h00;
    localparam logic [7:0] RST_IRQ_EDGE = 8'h80;
    localparam logic [7:0] ZERO = 8'h00;
endpackage

// file: bpo_pins_model.sv
// board model for the pin block: resolves every pad from all its drivers
`timescale 1ns/10ps
module bpo_pins_model (
    input wire logic core_clk,
    input wire logic [1:0] b_out,
    input wire logic [1:0] b_oe,
    input wire logic [1:0] b_pu,
    input wire logic [1:0] b_ext_en,
    input wire logic [1:0] b_ext_val,
    input wire logic [7:0] c_out,
    input wire logic [7:0] c_oe,
    input wire logic [7:0] c_ext_en,
    input wire logic [7:0] c_ext_val,
    input wire logic b3_out,
    input wire logic b3_oe,
    input wire logic b3_ext_val,
    output logic [1:0] b_level,
    output logic [7:0] c_level,
    output logic b3_level
);
    // undriven pads wander each cycle so a stale level never reads back
    logic wander = 1'b0;
    always @(posedge core_clk) wander <= ~wander;
    // the block's driver wins over the board; contention is not modelled
    assign b_level = (b_oe & b_out) | (~b_oe & b_ext_en & b_ext_val)
        | (~b_oe & ~b_ext_en & (b_pu | {2{wander}}));
    assign c_level = (c_oe & c_out) | (~c_oe & c_ext_en & c_ext_val)
        | (~c_oe & ~c_ext_en & {8{wander}});
    assign b3_level = b3_oe ? b3_out : b3_ext_val;
endmodule

// file: tb_bidir_port_with_overrides.sv
// self-checking bench for the two-port pin block
`timescale 1ns/10ps
module tb_bidir_port_with_overrides;
    logic core_clk = 1'b0, reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic [7:0] reg_rdata, port_c_pin_in, port_c_pin_out, port_c_pin_oe;
    logic [1:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe;
    logic [1:0] port_b_pullup_en, b_ext_en = 2'b11, b_ext_val = 2'b00;
    logic port_b_bit3_pin_in, analog_b_mode, capcomp2_capture_in;
    logic alt_b3_out, alt_b3_oe, change_event, change_irq_req;
    logic analog_at_reset_cfg = 1'b1, capcomp2_mux_cfg = 1'b1;
    logic capcomp2_en = 1'b0, capcomp2_out = 1'b0, capcomp2_oe = 1'b0;
    logic prog_enable = 1'b0, prog_serial_data_out = 1'b0;
    logic prog_serial_data_oe = 1'b0, prog_serial_clock, prog_serial_data_in;
    logic usb_en = 1'b0, usb_ext_xcvr = 1'b0, usb_xcvr_drive = 1'b0;
    logic usb_minus_out = 1'b0, usb_plus_out = 1'b0, usb_ext_oe_ctl = 1'b0;
    logic usb_minus_in, usb_plus_in, b3_ext_val = 1'b0;
    logic [7:0] periph_dir_ovr = 8'h00, periph_dir_val = 8'h00;
    logic [7:0] periph_out_ovr = 8'h00, periph_out_val = 8'h00;
    logic [7:0] c_ext_en = 8'h00, c_ext_val = 8'h00, lat, exp_q[$];
    int fail_count = 0, total_checks = 0, ev_count = 0;

    bpo_port dut_u (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe,
        .port_b_pullup_en, .port_b_bit3_pin_in, .port_c_pin_in,
        .port_c_pin_out, .port_c_pin_oe, .analog_at_reset_cfg, .analog_b_mode,
        .capcomp2_mux_cfg, .capcomp2_en, .capcomp2_out, .capcomp2_oe,
        .capcomp2_capture_in, .alt_b3_out, .alt_b3_oe, .prog_enable,
        .prog_serial_clock, .prog_serial_data_in, .prog_serial_data_out,
        .prog_serial_data_oe, .usb_en, .usb_ext_xcvr, .usb_xcvr_drive,
        .usb_minus_out, .usb_plus_out, .usb_ext_oe_ctl, .usb_minus_in,
        .usb_plus_in, .periph_dir_ovr, .periph_dir_val, .periph_out_ovr,
        .periph_out_val, .change_event, .change_irq_req);
    bpo_pins_model pins_u (.core_clk(core_clk), .b_out(port_b_pin_out),
        .b_oe(port_b_pin_oe), .b_pu(port_b_pullup_en), .b_ext_en(b_ext_en),
        .b_ext_val(b_ext_val), .c_out(port_c_pin_out), .c_oe(port_c_pin_oe),
        .c_ext_en(c_ext_en), .c_ext_val(c_ext_val), .b3_out(alt_b3_out),
        .b3_oe(alt_b3_oe), .b3_ext_val(b3_ext_val), .b_level(port_b_pin_in),
        .c_level(port_c_pin_in), .b3_level(port_b_bit3_pin_in));

    initial forever #50 core_clk = ~core_clk;

    task automatic chk(input logic [7:0] got, exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, e);
        wr(a, d);
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic do_reset(input logic s);
        analog_at_reset_cfg <= s;
        reset_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        wt(1);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge core_clk) rd_d <= reg_rd;
    always @(posedge core_clk) if (change_event === 1'b1) ev_count++;
    // read data stand only in the cycle after the strobe
    always @(negedge core_clk) begin
        if (rd_d === 1'b1 && exp_q.size() > 0)
            chk(reg_rdata, exp_q.pop_front(), "read data");
    end

    initial begin
        #(100 * 6000);
        fail_count++;
        conclude();
    end

    initial begin
        void'($urandom(51852));
        do_reset(1'b1);
        chk(port_c_pin_oe, 8'h00, "port c oe at reset");
        chk({7'h00, analog_b_mode}, 8'h01, "analog strap");
        rd(bpo_pkg::OFS_DIR_C, 8'hC7);
        rd(bpo_pkg::OFS_DIR_B, 8'hFF);
        rd(bpo_pkg::OFS_LAT_C, 8'h00);
        rd(bpo_pkg::OFS_IRQ_EDGE, 8'h80);
        rd(bpo_pkg::OFS_IRQ_MAIN, 8'h00);
        rd(bpo_pkg::OFS_STATUS, 8'h01);
        wr(4'hA, 8'hFF);
        rd(4'hA, 8'h00);
        $display("test reset done");
        c_ext_en <= 8'hFF;
        for (int i = 0; i < 3; i++) begin
            lat = 8'($urandom());
            c_ext_val <= ~lat;
            wr_rd(bpo_pkg::OFS_LAT_C, lat, lat & 8'hC7);
            wr(bpo_pkg::OFS_DIR_C, 8'h00);
            wt(3);
            chk(port_c_pin_oe, 8'hC7, "c outputs");
            chk(port_c_pin_out & 8'hC7, lat & 8'hC7, "c drive");
            rd(bpo_pkg::OFS_PIN_C, (lat & 8'hC7) | (~lat & 8'h30));
            wr(bpo_pkg::OFS_DIR_C, 8'hFF);
            wt(3);
            chk(port_c_pin_oe, 8'h00, "c inputs");
            rd(bpo_pkg::OFS_PIN_C, ~lat & 8'hF7);
            rd(bpo_pkg::OFS_LAT_C, lat & 8'hC7);
            wr(bpo_pkg::OFS_PIN_C, ~lat);
            rd(bpo_pkg::OFS_LAT_C, ~lat & 8'hC7);
        end
        $display("test port c direction done");
        wr_rd(bpo_pkg::OFS_DIR_C, 8'h40, 8'h40);
        periph_dir_ovr <= 8'h41;
        periph_dir_val <= 8'h01;
        periph_out_ovr <= 8'h01;
        periph_out_val <= 8'h01;
        wt(3);
        chk(port_c_pin_oe & 8'h41, 8'h01, "override dir");
        chk(port_c_pin_out & 8'h01, 8'h01, "override out");
        rd(bpo_pkg::OFS_DIR_C, 8'h40);
        periph_dir_ovr <= 8'h00;
        periph_out_ovr <= 8'h00;
        wr(bpo_pkg::OFS_DIR_C, 8'hFF);
        $display("test override done");
        usb_en <= 1'b1;
        usb_xcvr_drive <= 1'b1;
        usb_minus_out <= 1'b1;
        wt(3);
        chk(port_c_pin_oe & 8'h30, 8'h30, "usb drive");
        chk(port_c_pin_out & 8'h30, 8'h10, "usb levels");
        usb_xcvr_drive <= 1'b0;
        wt(3);
        chk(port_c_pin_oe & 8'h30, 8'h00, "usb receive");
        usb_ext_xcvr <= 1'b1;
        usb_xcvr_drive <= 1'b1;
        c_ext_val <= 8'hFF;
        for (int k = 0; k < 2; k++) begin
            usb_ext_oe_ctl <= k[0];
            wt(4);
            chk(port_c_pin_oe & 8'h34, 8'h04, "ext xcvr dir");
            chk(port_c_pin_out & 8'h04, {5'h00, k[0], 2'b00}, "oe ctl");
            chk({6'h00, usb_plus_in, usb_minus_in}, 8'h03, "usb rx");
            rd(bpo_pkg::OFS_PIN_C, 8'hC3 | {5'h00, k[0], 2'b00});
        end
        rd(bpo_pkg::OFS_STATUS, 8'h0D);
        usb_en <= 1'b0;
        $display("test usb done");
        wr(bpo_pkg::OFS_LAT_B, 8'h80);
        wr(bpo_pkg::OFS_DIR_B, 8'h00);
        wr(bpo_pkg::OFS_IRQ_EDGE, 8'h00);
        wt(3);
        chk({port_b_pin_oe, port_b_pin_out, 2'b00, port_b_pullup_en},
            8'hE0, "b outputs");
        wr(bpo_pkg::OFS_DIR_B, 8'hFF);
        wt(3);
        chk({6'h00, port_b_pullup_en}, 8'h03, "pull-ups on");
        wr(bpo_pkg::OFS_IRQ_EDGE, 8'h80);
        b_ext_en <= 2'b11;
        b_ext_val <= 2'b01;
        wt(3);
        chk({6'h00, port_b_pullup_en}, 8'h00, "pull-ups off");
        rd(bpo_pkg::OFS_PIN_B, 8'h40);
        wr(bpo_pkg::OFS_IRQ_MAIN, 8'h08);
        ev_count = 0;
        b_ext_val <= 2'b11;
        wt(6);
        chk(8'(ev_count), 8'h01, "one change pulse");
        chk({7'h00, change_irq_req}, 8'h01, "change request");
        rd(bpo_pkg::OFS_IRQ_MAIN, 8'h09);
        wr(bpo_pkg::OFS_IRQ_MAIN, 8'h08);
        wt(3);
        chk({7'h00, change_irq_req}, 8'h00, "change cleared");
        $display("test port b done");
        prog_enable <= 1'b1;
        wr(bpo_pkg::OFS_IRQ_EDGE, 8'h00);
        ev_count = 0;
        for (int k = 0; k < 4; k++) begin
            b_ext_val <= k[1:0];
            wt(4);
            chk({6'h00, prog_serial_data_in, prog_serial_clock}, 8'(k),
                "prog pins");
        end
        prog_serial_data_oe <= 1'b1;
        prog_serial_data_out <= 1'b1;
        wt(3);
        chk({port_b_pin_oe, 2'b00, port_b_pin_out[1], 1'b0,
             port_b_pullup_en}, 8'h88, "prog drive");
        chk(8'(ev_count), 8'h00, "no change in prog");
        prog_enable <= 1'b0;
        $display("test programming done");
        capcomp2_en <= 1'b1;
        capcomp2_oe <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            capcomp2_mux_cfg <= m[0];
            capcomp2_out <= 1'b1;
            b3_ext_val <= ~m[0];
            wt(4);
            chk({4'h0, alt_b3_out, alt_b3_oe, port_c_pin_oe[1],
                capcomp2_capture_in}, {4'h0, ~m[0], ~m[0], m[0], 1'b1},
                "capcomp2 route");
        end
        capcomp2_en <= 1'b0;
        $display("test capcomp2 done");
        do_reset(1'b0);
        chk({7'h00, analog_b_mode}, 8'h00, "analog strap low");
        chk(port_c_pin_oe, 8'h00, "c inputs again");
        rd(bpo_pkg::OFS_STATUS, 8'h00);
        rd(bpo_pkg::OFS_DIR_C, 8'hC7);
        wt(2);
        $display("test second reset done");
        conclude();
    end
endmodule
